// [sysrc_assertions.sv]
// Checker for reset sources and stop control at the top module ports
module sysrc_assertions (
   input logic ref_clk,
   input logic resetn,
   input logic cpu_illegal_insn,
   input logic cpu_stop_insn,
   input logic cpu_opcode_fetch,
   input logic cpu_addr_unmapped,
   input logic module_irq,
   input logic break_req,
   input logic rst_pin_out,
   input logic rst_pin_oe_n,
   input logic osc_clk_en,
   input logic dbl_osc_clk_en,
   input logic irq_stack_go
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [12:0] wake_cnt_ff;
   logic [12:0] nxt_wake_cnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // ==========================================
   // Wake wait counter, too long for a repetition
   assign nxt_wake_cnt = (!osc_clk_en && (module_irq || break_req)) ? wake_cnt_ff + 13'h1 : 13'h0;
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) wake_cnt_ff <= 13'h0;
      else wake_cnt_ff <= nxt_wake_cnt;
   end
   // ==========================================
   // Properties
   property p_pin_drive; !rst_pin_out; endproperty
   property p_ill; cpu_illegal_insn |=> !rst_pin_oe_n [*8]; endproperty
   property p_stop_ill; cpu_stop_insn && osc_clk_en |=> !rst_pin_oe_n || !osc_clk_en; endproperty
   property p_addr; cpu_opcode_fetch && cpu_addr_unmapped |=> !rst_pin_oe_n; endproperty
   property p_clk_pair; osc_clk_en == dbl_osc_clk_en; endproperty
   property p_stop_entry; $fell(osc_clk_en) |-> $past(cpu_stop_insn); endproperty
   property p_stack; irq_stack_go |-> !$past(osc_clk_en, 16); endproperty
   property p_wake; wake_cnt_ff < 13'd4200; endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("reset pin driven high");
   a_ill: assert property (p_ill) else $error("no reset after illegal insn");
   a_stop_ill: assert property (p_stop_ill) else $error("stop insn ignored");
   a_addr: assert property (p_addr) else $error("no reset after bad fetch");
   a_clk_pair: assert property (p_clk_pair) else $error("clock enables differ");
   a_stop_entry: assert property (p_stop_entry) else $error("clocks off without stop");
   a_stack: assert property (p_stack) else $error("stacking before recovery");
   a_wake: assert property (p_wake) else $error("no wake from stop");
   c_stack: cover property (irq_stack_go);
   c_stop: cover property ($fell(osc_clk_en));
   c_rst: cover property ($fell(rst_pin_oe_n));
endmodule // sysrc_assertions

bind sysrc_top sysrc_assertions u_chk (.*);

// [sysrc_cpu_model.sv]
// Behavioural CPU fetch and decode signals chosen by an operation code
module sysrc_cpu_model (
   input logic [2:0] op,
   output logic cpu_illegal_insn,
   output logic cpu_stop_insn,
   output logic cpu_opcode_fetch,
   output logic cpu_addr_unmapped
);
   timeunit 1ns;
   timeprecision 1ps;
   // Op 1 illegal, 2 stop, 3 unmapped opcode fetch, 4 unmapped data fetch
   assign cpu_illegal_insn = (op == 3'h1);
   assign cpu_stop_insn = (op == 3'h2);
   assign cpu_opcode_fetch = (op == 3'h3);
   assign cpu_addr_unmapped = (op >= 3'h3);
endmodule // sysrc_cpu_model

// [sysrc_regs.vh]
// Constants for the system reset and stop control block
//
// Overview of operation
// - Watchdog overflow forces an internal reset and sets the watchdog cause flag.
// - Every internal reset source drives the active-low reset pin low.
// - Any write to the service location clears watchdog and divider stages 12..5.
// - Divider output ticks the watchdog at least every 4080 doubled-clock cycles.
// - Monitor mode with test voltage on reset or irq pin disables the watchdog.
// - In break state, test voltage on the reset pin disables the watchdog.
// - Illegal instruction decode sets its cause flag and resets the device.
// - With stop enable clear, a stop instruction is an illegal instruction reset.
// - Unmapped opcode fetch, confirmed as opcode fetch, sets address flag and resets.
// - Data fetch from an unmapped address causes no reset.
// - Stop entry resets the divider and gates off both system clocks.
// - Stop mode ends on module interrupt, break or reset.
// - Interrupt stacking waits until the stop recovery delay has fully elapsed.
// - Short recovery bit set gives 32 cycles, clear gives 4096 cycles.
// - Stop exit through the reset pin always uses the long delay.
// - Break during stop mode sets the break stop/wait flag.
// - Divider held in reset from stop until recovery, then times recovery.
// - Watchdog disable bit at 1 disables the watchdog, at 0 enables it.
// - Supply-drop inhibit disable bit at 1 disables the supply-drop reset.
// - Break stop/wait flag reads 1 only after a break exit from low power.
`ifndef SYSRC_REGS_VH
`define SYSRC_REGS_VH

// ===========================================================
// Register byte addresses
`define SYSRC_ADDR_CONFIG 12'h000
`define SYSRC_ADDR_CAUSE 12'h004
`define SYSRC_ADDR_BREAK 12'h008
`define SYSRC_ADDR_SERVICE 12'h00c
`define SYSRC_ADDR_CTRL 12'h010
`define SYSRC_ADDR_STATUS 12'h014

// ===========================================================
// Configuration fields and reset value
`define SYSRC_CFG_WDOG_DIS 0
`define SYSRC_CFG_STOP_EN 1
`define SYSRC_CFG_SHORT_REC 7
`define SYSRC_CFG_LVI_DIS 5
`define SYSRC_CFG_RESET 8'h00

// ===========================================================
// Cause flag fields
`define SYSRC_CAUSE_ILADDR 3
`define SYSRC_CAUSE_ILINSN 4
`define SYSRC_CAUSE_WDOG 5
`define SYSRC_CAUSE_SUPPLY 1
`define SYSRC_CAUSE_PIN 6

// ===========================================================
// Break and control fields
`define SYSRC_BRK_BREAK_STOP_WAIT_FLAG 1
`define SYSRC_CTRL_BCFE 7

// ===========================================================
// Divider and timing
`define SYSRC_DIV_W 13
`define SYSRC_DIV_TAP 11
`define SYSRC_DIV_CLR_LO 5
`define SYSRC_WDOG_W 6
`define SYSRC_REC_SHORT 13'd32
`define SYSRC_REC_LONG 13'd4096
`define SYSRC_RST_PULSE 6'd63
`define SYSRC_PIN_ECHO 2'd3

`endif

// [sysrc_top.v]
// System reset sources, watchdog and stop mode control with AHB-Lite registers
`include "sysrc_regs.vh"

module sysrc_top (
   input wire ref_clk,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire cpu_illegal_insn,
   input wire cpu_stop_insn,
   input wire cpu_opcode_fetch,
   input wire cpu_addr_unmapped,
   input wire module_irq,
   input wire break_req,
   input wire monitor_mode,
   input wire rst_pin_in,
   input wire rst_pin_vtst,
   input wire irq_pin_vtst,
   input wire supply_low,
   output reg rst_pin_out,
   output reg rst_pin_oe_n,
   output reg osc_clk_en,
   output reg dbl_osc_clk_en,
   output reg irq_stack_go,
   output reg supply_drop_reset_en
);

   // ===========================================================
   // Reset release and pin synchronisers
   wire rst_n;
   wire pin_rst_low_n;
   wire rst_vtst_n;
   wire irq_vtst_n;
   wire sup_low_n;
   wire mon_mode_n;
   sysrc_sync2 #(
      .RST_VAL(1'b0)
   ) u_rst_sync (
      .clk(ref_clk),
      .rst_n(resetn),
      .d(1'b1),
      .q(rst_n)
   );
   // Pins idle high, the reset pin as is and the others after inversion, so no false event follows reset
   sysrc_sync2 #(
      .RST_VAL(1'b1)
   ) u_pin_rst_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d(rst_pin_in),
      .q(pin_rst_low_n)
   );
   sysrc_sync2 #(
      .RST_VAL(1'b1)
   ) u_rst_vtst_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d(~rst_pin_vtst),
      .q(rst_vtst_n)
   );
   sysrc_sync2 #(
      .RST_VAL(1'b1)
   ) u_irq_vtst_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d(~irq_pin_vtst),
      .q(irq_vtst_n)
   );
   sysrc_sync2 #(
      .RST_VAL(1'b1)
   ) u_sup_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d(~supply_low),
      .q(sup_low_n)
   );
   sysrc_sync2 #(
      .RST_VAL(1'b1)
   ) u_mon_sync (
      .clk(ref_clk),
      .rst_n(rst_n),
      .d(~monitor_mode),
      .q(mon_mode_n)
   );
   wire pin_rst_low = ~pin_rst_low_n;
   wire rst_vtst = ~rst_vtst_n;
   wire irq_vtst = ~irq_vtst_n;
   wire sup_low = ~sup_low_n;
   wire mon_mode = ~mon_mode_n;

   // ===========================================================
   // AHB-Lite slave
   reg ph_wr_ff;
   reg ph_rd_ff;
   reg [11:0] ph_addr_ff;
   wire take = hsel & htrans[1] & hready;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_wr_ff <= 1'b0;
         ph_rd_ff <= 1'b0;
         ph_addr_ff <= 12'h000;
      end else begin
         ph_wr_ff <= take & hwrite;
         ph_rd_ff <= take & ~hwrite;
         if (take) ph_addr_ff <= haddr[11:0];
      end
   end
   wire wr_cfg = ph_wr_ff & (ph_addr_ff == `SYSRC_ADDR_CONFIG);
   wire wr_cause = ph_wr_ff & (ph_addr_ff == `SYSRC_ADDR_CAUSE);
   wire wr_brk = ph_wr_ff & (ph_addr_ff == `SYSRC_ADDR_BREAK);
   wire wr_srv = ph_wr_ff & (ph_addr_ff == `SYSRC_ADDR_SERVICE);
   wire wr_ctrl = ph_wr_ff & (ph_addr_ff == `SYSRC_ADDR_CTRL);

   // ===========================================================
   // Configuration and control registers
   reg [7:0] cfg_ff;
   reg [7:0] ctrl_ff;
   reg in_break_ff;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff <= `SYSRC_CFG_RESET;
         ctrl_ff <= 8'h00;
      end else begin
         if (wr_cfg) cfg_ff <= hwdata[7:0];
         if (wr_ctrl) ctrl_ff <= hwdata[7:0];
      end
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) in_break_ff <= 1'b0;
      else in_break_ff <= break_req;
   end

   // ===========================================================
   // Stop state machine
   localparam ST_RUN = 2'd0;
   localparam ST_STOP = 2'd1;
   localparam ST_REC = 2'd2;
   reg [1:0] st_ff;
   reg [1:0] nxt_st;
   reg long_rec_ff;
   reg [`SYSRC_DIV_W-1:0] div_ff;
   reg [`SYSRC_DIV_W-1:0] nxt_div;
   wire [`SYSRC_DIV_W-1:0] rec_len = long_rec_ff ? `SYSRC_REC_LONG : `SYSRC_REC_SHORT;
   wire rec_done = (st_ff == ST_REC) && (div_ff == rec_len - 13'd1);
   wire stop_ok = cpu_stop_insn & cfg_ff[`SYSRC_CFG_STOP_EN];
   wire wake = module_irq | break_req | pin_rst_low;

   always @* begin
      nxt_st = st_ff;
      case (st_ff)
         ST_RUN: if (stop_ok) nxt_st = ST_STOP;
         ST_STOP: if (wake) nxt_st = ST_REC;
         ST_REC: if (rec_done) nxt_st = ST_RUN;
         default: nxt_st = ST_RUN;
      endcase
   end

   // Divider: held at zero in stop, times recovery, partly cleared on service
   always @* begin
      nxt_div = div_ff + 13'd1;
      if (st_ff == ST_STOP || stop_ok) nxt_div = {`SYSRC_DIV_W{1'b0}};
      else if (rec_done) nxt_div = {`SYSRC_DIV_W{1'b0}};
      else if (wr_srv) nxt_div = {{(`SYSRC_DIV_W-`SYSRC_DIV_CLR_LO){1'b0}},
         div_ff[`SYSRC_DIV_CLR_LO-1:0]};
   end

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) st_ff <= ST_RUN;
      else st_ff <= nxt_st;
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) div_ff <= {`SYSRC_DIV_W{1'b0}};
      else div_ff <= nxt_div;
   end
   // Delay length follows the stop cycles, so the exit cycle decides it
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         long_rec_ff <= 1'b1;
      end else if (st_ff == ST_STOP) begin
         long_rec_ff <= ~cfg_ff[`SYSRC_CFG_SHORT_REC]
            | pin_rst_low;
      end
   end

   // ===========================================================
   // Watchdog
   reg [`SYSRC_WDOG_W-1:0] wdog_ff;
   reg div_tap_ff;
   // Both tap edges tick, keeping the interval well under 4080 cycles
   wire div_tick = div_ff[`SYSRC_DIV_TAP] ^ div_tap_ff;
   // Only the disable bit and the test voltage detect may gate it, so noise cannot disable it
   wire wdog_off = cfg_ff[`SYSRC_CFG_WDOG_DIS]
      | (mon_mode & (rst_vtst | irq_vtst))
      | (in_break_ff & rst_vtst);
   wire wdog_ovf = ~wdog_off & div_tick & (&wdog_ff);
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_ff <= {`SYSRC_WDOG_W{1'b0}};
         div_tap_ff <= 1'b0;
      end else begin
         div_tap_ff <= div_ff[`SYSRC_DIV_TAP];
         if (wr_srv || wdog_off) wdog_ff <= {`SYSRC_WDOG_W{1'b0}};
         else if (div_tick) wdog_ff <= wdog_ff + 6'd1;
      end
   end

   // ===========================================================
   // Reset sources and cause flags
   wire ill_insn = (st_ff == ST_RUN) & (cpu_illegal_insn
      | (cpu_stop_insn & ~cfg_ff[`SYSRC_CFG_STOP_EN]));
   // Opcode fetch qualifier keeps data fetches harmless
   wire ill_addr = cpu_addr_unmapped & cpu_opcode_fetch;
   wire lvi_en = ~cfg_ff[`SYSRC_CFG_LVI_DIS];
   wire sup_rst = sup_low & lvi_en;
   wire int_rst = wdog_ovf | ill_insn | ill_addr | sup_rst;

   wire [5:0] pulse_cnt;
   wire pulse_busy;
   wire echo_busy;
   reg [7:0] cause_ff;
   reg break_stop_wait_flag_ff;
   sysrc_downcnt #(
      .W(6)
   ) u_pulse (
      .clk(ref_clk),
      .rst_n(rst_n),
      .load(int_rst),
      .load_val(`SYSRC_RST_PULSE),
      .count(pulse_cnt),
      .busy(pulse_busy)
   );
   // Our own pulse echoes back through the pin synchroniser for a few cycles
   sysrc_downcnt #(
      .W(2)
   ) u_echo (
      .clk(ref_clk),
      .rst_n(rst_n),
      .load(pulse_busy),
      .load_val(`SYSRC_PIN_ECHO),
      .count(),
      .busy(echo_busy)
   );
   wire ext_pin_rst = pin_rst_low & ~pulse_busy & ~echo_busy;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_ff <= 8'h00;
      end else if (int_rst) begin
         // New cause replaces old ones; a set beats a same-cycle clear
         cause_ff <= 8'h00;
         cause_ff[`SYSRC_CAUSE_WDOG] <= wdog_ovf;
         cause_ff[`SYSRC_CAUSE_ILINSN] <= ill_insn;
         cause_ff[`SYSRC_CAUSE_ILADDR] <= ill_addr;
         cause_ff[`SYSRC_CAUSE_SUPPLY] <= sup_rst;
      end else if (ext_pin_rst) begin
         cause_ff <= 8'h00;
         cause_ff[`SYSRC_CAUSE_PIN] <= 1'b1;
      end else if (wr_cause) begin
         cause_ff <= 8'h00;
      end
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) break_stop_wait_flag_ff <= 1'b0;
      else if (st_ff == ST_STOP && break_req) break_stop_wait_flag_ff <= 1'b1;
      else if (wr_brk && (!in_break_ff || ctrl_ff[`SYSRC_CTRL_BCFE])
         && !hwdata[`SYSRC_BRK_BREAK_STOP_WAIT_FLAG]) break_stop_wait_flag_ff <= 1'b0;
   end

   // ===========================================================
   // Outputs and read data
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (haddr[11:0])
         `SYSRC_ADDR_CONFIG: rd_mux[7:0] = cfg_ff;
         `SYSRC_ADDR_CAUSE: rd_mux[7:0] = cause_ff;
         `SYSRC_ADDR_BREAK: rd_mux[`SYSRC_BRK_BREAK_STOP_WAIT_FLAG] = break_stop_wait_flag_ff;
         `SYSRC_ADDR_CTRL: rd_mux[7:0] = ctrl_ff;
         `SYSRC_ADDR_STATUS: rd_mux[2:0] = {long_rec_ff, st_ff};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   wire stopped = (nxt_st == ST_STOP) || (nxt_st == ST_REC);
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         rst_pin_out <= 1'b0;
         rst_pin_oe_n <= 1'b1;
         osc_clk_en <= 1'b1;
         dbl_osc_clk_en <= 1'b1;
         irq_stack_go <= 1'b0;
         supply_drop_reset_en <= 1'b1;
      end else begin
         hrdata <= (take & ~hwrite) ? rd_mux : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         rst_pin_out <= 1'b0;
         rst_pin_oe_n <= ~(int_rst | (pulse_cnt > 6'd1));
         osc_clk_en <= ~stopped;
         dbl_osc_clk_en <= ~stopped;
         irq_stack_go <= rec_done & module_irq;
         supply_drop_reset_en <= lvi_en;
      end
   end
endmodule // sysrc_top

// ===========================================================
// Two-flop synchroniser, shared by reset release and pins
module sysrc_sync2 #(
   parameter RST_VAL = 1'b0
) (
   input wire clk,
   input wire rst_n,
   input wire d,
   output wire q
);
   reg meta_ff;
   reg sync_ff;
   // Only the second flop is read, the first may be metastable
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end
   assign q = sync_ff;
endmodule // sysrc_sync2

// ===========================================================
// Load and count down to zero, for pulse and echo windows
module sysrc_downcnt #(
   parameter W = 6
) (
   input wire clk,
   input wire rst_n,
   input wire load,
   input wire [W-1:0] load_val,
   output wire [W-1:0] count,
   output wire busy
);
   reg [W-1:0] cnt_ff;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_ff <= {W{1'b0}};
      else if (load) cnt_ff <= load_val;
      else if (busy) cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
   end
   assign count = cnt_ff;
   assign busy = |cnt_ff;
endmodule // sysrc_downcnt

// [sysrc_top_test.sv]
// Self-checking bench for the reset and stop control block
module sysrc_top_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, resetn = 0, hsel = 0, hwrite = 0, module_irq = 0, break_req = 0, s;
   logic ext_pin = 1;
   logic [31:0] haddr = 0, hwdata = 0, r;
   logic [1:0] htrans = 0;
   logic [2:0] op = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, oe_n, osc_en, dbl_en, stack_go, sd_en, pin_out, ill, stp, ofe, unm;
   int errors = 0, n_tests = 0, seed = 44, i, n;
   sysrc_cpu_model cpu_m (.op(op), .cpu_illegal_insn(ill), .cpu_stop_insn(stp),
      .cpu_opcode_fetch(ofe), .cpu_addr_unmapped(unm));
   sysrc_top dut (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_illegal_insn(ill),
      .cpu_stop_insn(stp), .cpu_opcode_fetch(ofe), .cpu_addr_unmapped(unm),
      .module_irq(module_irq), .break_req(break_req), .monitor_mode(1'b0),
      .rst_pin_in(oe_n ? ext_pin : pin_out), .rst_pin_vtst(1'b0), .irq_pin_vtst(1'b0),
      .supply_low(1'b0), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n), .osc_clk_en(osc_en),
      .dbl_osc_clk_en(dbl_en), .irq_stack_go(stack_go), .supply_drop_reset_en(sd_en));
   initial forever #4 ref_clk = ~ref_clk;
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      hsel <= 1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic cpu(input logic [2:0] o);
      @(posedge ref_clk);
      op <= o;
      @(posedge ref_clk);
      op <= 3'h0;
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (4) @(posedge ref_clk);
      resetn <= 1;
      repeat (3) @(posedge ref_clk);
      bus(1, 32'hc, 32'h0);
      chk({osc_en, dbl_en, oe_n, sd_en}, 4'hf);
      chk({hresp, pin_out}, 2'h0);
      bus(0, 32'h0, 32'h0);
      chk(r, 32'h0);
      for (i = 0; i < 4; i++) begin
         n = $random(seed);
         bus(1, 32'h0, n & 32'hfd);
         bus(0, 32'h0, 32'h0);
         chk(r[7:0], n & 32'hfd);
         chk(sd_en, !n[5]);
      end
      bus(0, 32'h40, 32'h0);
      chk(r, 32'h0);
      $display("config test done");
      for (i = 1; i < 5; i++) begin
         bus(1, 32'h0, 32'h0);
         bus(1, 32'h4, 32'h0);
         cpu(i);
         @(negedge ref_clk);
         chk(oe_n, i == 4);
         repeat (70) @(posedge ref_clk);
         bus(0, 32'h4, 32'h0);
         chk(r[4:3], i == 4 ? 0 : (i == 3 ? 1 : 2));
      end
      $display("reset source test done");
      for (i = 0; i < 3; i++) begin
         bus(1, 32'h0, i == 1 ? 32'h02 : 32'h82);
         cpu(3'h2);
         @(negedge ref_clk);
         chk({osc_en, dbl_en}, 2'h0);
         repeat (($random(seed) & 7) + 3) @(posedge ref_clk);
         if (i == 1) break_req <= 1;
         else if (i == 2) ext_pin <= 0;
         else module_irq <= 1;
         n = 0;
         s = 0;
         do begin
            @(posedge ref_clk);
            n++;
            s = s | stack_go;
         end while (osc_en !== 1'b1 && n < 5000);
         repeat (3) begin
            @(posedge ref_clk);
            s = s | stack_go;
         end
         chk(n >= (i ? 4096 : 32) && n <= (i ? 4100 : 36), 1);
         chk(s, !i);
         module_irq <= 0;
         break_req <= 0;
         ext_pin <= 1;
         bus(0, 32'h8, 32'h0);
         chk(r[1], i != 0);
      end
      $display("stop test done");
      end_of_test;
   end
   initial begin
      #200000;
      errors++;
      end_of_test;
   end
endmodule // sysrc_top_test
